/* File: hw/rcs_sequencer.sv */
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_sequencer #(
	parameter logic [21:0] POWER_UP_TIMER_CYCLES    = 22'(`RCS_CYC(`RCS_T_POWER_UP_TIMER_NS)),
	parameter logic [21:0] MONITOR_CYCLES =
		22'(`RCS_CYC(`RCS_T_MONITOR_NS))
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// pins
	input  wire logic        master_clear_pin_n,
	input  wire logic        brownout_detect,
	input  wire logic        osc_clk_in,
	// core events, one-cycle pulses or levels
	input  wire logic        software_reset_req,
	input  wire logic        watchdog_timeout,
	input  wire logic        trap_conflict,
	input  wire logic        illegal_access,
	input  wire logic        power_save_sleep,
	input  wire logic        power_save_idle,
	input  wire logic        wake_event,
	// configuration fuses
	input  wire logic        watchdog_fuse_enable,
	input  wire logic        clock_switch_enable,
	input  wire logic [2:0]  oscillator_select_fuse,
	input  wire logic        regulator_enable,
	input  wire logic        clock_monitor_enable,
	// status out
	output logic             system_reset_signal,
	output logic             cpu_run,
	output logic             clock_ready,
	output logic             watchdog_enable,
	output logic      [2:0]  clock_source,
	output logic             osc_fail_trap,
	output logic             clock_monitor_active
);

	localparam int TW = `RCS_TMR_W;
	localparam logic [TW-1:0] POWERON_CYC = TW'(`RCS_CYC(`RCS_T_POWERON_NS));
	localparam logic [TW-1:0] STARTUP_CYC = TW'(`RCS_CYC(`RCS_T_STARTUP_NS));
	localparam logic [TW-1:0] INTERNAL_CYC =
		TW'(`RCS_CYC(`RCS_T_INTERNAL_NS));
	localparam logic [TW-1:0] LOCK_CYC = TW'(`RCS_CYC(`RCS_T_LOCK_NS));

	function automatic logic needs_ost(input logic [2:0] src);
		needs_ost = (src == `RCS_SRC_PRI) || (src == `RCS_SRC_PRIPLL) ||
			(src == `RCS_SRC_SEC);
	endfunction : needs_ost

	function automatic logic needs_lock(input logic [2:0] src);
		needs_lock = (src == `RCS_SRC_FRCPLL) || (src == `RCS_SRC_PRIPLL) ||
			(src == `RCS_SRC_EXTPLL);
	endfunction : needs_lock

	rcs_pkg::rcs_state_t state;
	rcs_pkg::rcs_state_t next_state;
	logic [2:0]    pins_s;
	logic          master_clear_pin_n_s;
	logic          brownout_s;
	logic          osc_s;
	logic          osc_prev;
	logic          brownout_evt;
	logic          soft_evt;
	logic          seq_load;
	logic [TW-1:0] seq_val;
	logic          seq_busy;
	logic [TW-1:0] startup_cyc;
	logic          por_loaded;
	logic          sys_prev;
	logic          released;
	logic          asleep;
	logic [15:0]   cause;
	logic [15:0]   next_cause;
	logic [15:0]   lane_mask;
	logic [2:0]    next_src;
	logic          restart_q;
	logic [9:0]    ost_cnt;
	logic          ost_done;
	logic          ost_fin;
	logic          lock_start;
	logic          lock_wait;
	logic          lock_busy;
	logic          mon_busy;
	logic          mon_pending;
	logic          mon_check;
	logic          fallback;
	logic          ack;
	logic          take;
	logic          cause_wr;
	logic          osc_wr;
	logic          stat_wr;

	// pins cross into clk_sys first
	rcs_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d_async ({osc_clk_in, brownout_detect, master_clear_pin_n}),
		.q       (pins_s)
	);
	assign master_clear_pin_n_s   = pins_s[0];
	assign brownout_s = pins_s[1];
	assign osc_s      = pins_s[2];

	assign brownout_evt = brownout_s;
	assign soft_evt = !master_clear_pin_n_s || watchdog_timeout || software_reset_req ||
		trap_conflict || illegal_access;
	assign startup_cyc = regulator_enable ? STARTUP_CYC : POWER_UP_TIMER_CYCLES;

	// reset sequence
	always_comb
	begin
		next_state = state;
		seq_load   = 1'b0;
		seq_val    = '0;
		if (brownout_evt)
		begin
			next_state = rcs_pkg::RCS_ST_STARTUP;
			seq_load   = 1'b1;
			seq_val    = startup_cyc;
		end
		else if (soft_evt)
		begin
			next_state = rcs_pkg::RCS_ST_INTERNAL;
			seq_load   = 1'b1;
			seq_val    = INTERNAL_CYC;
		end
		else
		begin
			unique case (state)
				rcs_pkg::RCS_ST_POWERON:
					if (!por_loaded)
					begin
						seq_load = 1'b1;
						seq_val  = POWERON_CYC;
					end
					else if (!seq_busy)
					begin
						next_state = rcs_pkg::RCS_ST_STARTUP;
						seq_load   = 1'b1;
						seq_val    = startup_cyc;
					end
				rcs_pkg::RCS_ST_STARTUP:
					if (!seq_busy)
					begin
						next_state = rcs_pkg::RCS_ST_INTERNAL;
						seq_load   = 1'b1;
						seq_val    = INTERNAL_CYC;
					end
				rcs_pkg::RCS_ST_INTERNAL:
					if (!seq_busy)
						next_state = rcs_pkg::RCS_ST_RUN;
				rcs_pkg::RCS_ST_RUN:
					if (wake_event && asleep && regulator_enable)
					begin
						next_state = rcs_pkg::RCS_ST_WAKE;
						seq_load   = 1'b1;
						seq_val    = STARTUP_CYC;
					end
				rcs_pkg::RCS_ST_WAKE:
					if (!seq_busy)
						next_state = rcs_pkg::RCS_ST_RUN;
				default:
					next_state = rcs_pkg::RCS_ST_POWERON;
			endcase
		end
	end

	rcs_delay #(.W(TW)) u_seq_tmr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (seq_load),
		.count   (seq_val),
		.busy    (seq_busy)
	);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state               <= rcs_pkg::RCS_ST_POWERON;
			por_loaded          <= 1'b0;
			system_reset_signal <= 1'b1;
			sys_prev            <= 1'b1;
		end
		else
		begin
			state      <= next_state;
			por_loaded <= 1'b1;
			system_reset_signal <= (next_state != rcs_pkg::RCS_ST_RUN) &&
				(next_state != rcs_pkg::RCS_ST_WAKE);
			sys_prev   <= system_reset_signal;
		end
	end
	assign released = sys_prev && !system_reset_signal;

	// code runs only in run state with a released clock
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cpu_run <= 1'b0;
		else
			cpu_run <= (state == rcs_pkg::RCS_ST_RUN) && clock_ready;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || system_reset_signal || wake_event)
			asleep <= 1'b0;
		else if (power_save_sleep)
			asleep <= 1'b1;
	end

	// reset cause flags, hardware set beats software write
	assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	always_comb
	begin
		next_cause = cause;
		if (cause_wr)
			next_cause = (cause & ~(lane_mask & `RCS_CAUSE_WMASK)) |
				(avs_writedata[15:0] & lane_mask & `RCS_CAUSE_WMASK);
		if (power_save_sleep || power_save_idle)
			next_cause[`RCS_BIT_WDOG] = 1'b0;
		next_cause[`RCS_BIT_BROWNOUT] =
			next_cause[`RCS_BIT_BROWNOUT] | brownout_evt;
		next_cause[`RCS_BIT_ILLEGAL] =
			next_cause[`RCS_BIT_ILLEGAL] | illegal_access;
		next_cause[`RCS_BIT_TRAP]  = next_cause[`RCS_BIT_TRAP] | trap_conflict;
		next_cause[`RCS_BIT_PIN]   = next_cause[`RCS_BIT_PIN] | !master_clear_pin_n_s;
		next_cause[`RCS_BIT_SOFT]  =
			next_cause[`RCS_BIT_SOFT] | software_reset_req;
		next_cause[`RCS_BIT_WDOG]  =
			next_cause[`RCS_BIT_WDOG] | watchdog_timeout;
		next_cause[`RCS_BIT_SLEEP] =
			next_cause[`RCS_BIT_SLEEP] | power_save_sleep;
		next_cause[`RCS_BIT_IDLE]  = next_cause[`RCS_BIT_IDLE] | power_save_idle;
	end

	// power-on and software clear flags; sleep or idle entry also clears the watchdog flag
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cause <= `RCS_CAUSE_RESET;
		else
			cause <= next_cause;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			watchdog_enable <= 1'b0;
		else
			watchdog_enable <= watchdog_fuse_enable ||
				cause[`RCS_BIT_SWDOG_EN];
	end

	// clock source selection
	assign fallback = mon_check && clock_monitor_enable && !clock_ready;
	always_comb
	begin
		next_src = clock_source;
		if (fallback)
			next_src = `RCS_SRC_FRC;
		else if (brownout_evt || (soft_evt && !clock_switch_enable))
			next_src = oscillator_select_fuse;
		else if (osc_wr && clock_switch_enable && !soft_evt)
			next_src = avs_writedata[`RCS_CURRENT_OSCILLATOR_FIELD_MSB:`RCS_CURRENT_OSCILLATOR_FIELD_LSB];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			clock_source <= oscillator_select_fuse;
			restart_q    <= 1'b0;
		end
		else
		begin
			clock_source <= next_src;
			restart_q    <= !por_loaded || brownout_evt ||
				(next_src != clock_source);
		end
	end

	// start-up edge count on the oscillator, beside the reset delay
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			osc_prev <= 1'b0;
		else
			osc_prev <= osc_s;
	end
	assign ost_fin = osc_s && !osc_prev && !ost_done &&
		(ost_cnt == `RCS_OST_LAST);

	always_ff @(posedge clk_sys)
	begin
		if (rst || restart_q)
		begin
			ost_cnt  <= '0;
			ost_done <= 1'b0;
		end
		else if (osc_s && !osc_prev && !ost_done)
		begin
			ost_cnt  <= ost_cnt + 10'h1;
			ost_done <= (ost_cnt == `RCS_OST_LAST);
		end
	end

	// pll lock follows the edge count for crystal pll sources
	assign lock_start = (restart_q && !needs_ost(clock_source)) || ost_fin;
	always_ff @(posedge clk_sys)
	begin
		if (rst || restart_q)
			lock_wait <= 1'b1;
		else if (lock_start)
			lock_wait <= 1'b0;
	end

	rcs_delay #(.W(TW)) u_lock_tmr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (lock_start),
		.count   (LOCK_CYC),
		.busy    (lock_busy)
	);

	assign clock_ready = !restart_q &&
		(ost_done || !needs_ost(clock_source)) &&
		(!(lock_wait || lock_busy) || !needs_lock(clock_source));

	// fail-safe monitor start after release
	rcs_delay #(.W(TW)) u_mon_tmr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (released),
		.count   ((needs_ost(clock_source) || needs_lock(clock_source)) ?
			MONITOR_CYCLES : TW'(1)),
		.busy    (mon_busy)
	);
	assign mon_check = mon_pending && !mon_busy;

	always_ff @(posedge clk_sys)
	begin
		if (rst || system_reset_signal)
		begin
			mon_pending          <= 1'b0;
			clock_monitor_active <= 1'b0;
		end
		else if (released)
			mon_pending <= 1'b1;
		else if (mon_check)
		begin
			mon_pending          <= 1'b0;
			clock_monitor_active <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			osc_fail_trap <= 1'b0;
		else if (fallback)
			osc_fail_trap <= 1'b1;
		else if (stat_wr && avs_byteenable[0] &&
			avs_writedata[`RCS_ST_OSC_FAIL])
			osc_fail_trap <= 1'b0;
	end

	// avalon slave, one wait state per access
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign take     = avs_write && ack;
	assign cause_wr = take && (avs_address == `RCS_ADDR_CAUSE);
	assign osc_wr   = take && (avs_address == `RCS_ADDR_OSC) &&
		avs_byteenable[1];
	assign stat_wr  = take && (avs_address == `RCS_ADDR_STATUS);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ack          <= 1'b0;
			avs_readdata <= '0;
		end
		else
		begin
			ack <= (avs_read || avs_write) && !ack;
			if (avs_read && !ack)
			begin
				avs_readdata <= '0;
				unique case (avs_address)
					`RCS_ADDR_CAUSE:
						avs_readdata[15:0] <= cause;
					`RCS_ADDR_OSC:
						avs_readdata[`RCS_CURRENT_OSCILLATOR_FIELD_MSB:`RCS_CURRENT_OSCILLATOR_FIELD_LSB] <= clock_source;
					`RCS_ADDR_STATUS:
						avs_readdata[5:0] <= {osc_fail_trap,
							clock_monitor_active, cpu_run, clock_ready,
							system_reset_signal, watchdog_enable};
					default:
						avs_readdata <= '0;
				endcase
			end
		end
	end

	// assertions
	logic [TW-1:0] rst_len;
	always_ff @(posedge clk_sys)
	begin
		if (rst || !system_reset_signal)
			rst_len <= '0;
		else if (rst_len != '1)
			rst_len <= rst_len + TW'(1);
	end

	sequence s_fast_release;
		released && !needs_ost(clock_source) && !needs_lock(clock_source);
	endsequence
	sequence s_monitor_up;
		##3 (clock_monitor_active || system_reset_signal);
	endsequence

	a_por_flags: assert property (@(posedge clk_sys)
		$fell(rst) |-> cause[0] && cause[13:1] == 13'h0)
		else $error("power-on cause value wrong");
	a_brownout_flag: assert property (@(posedge clk_sys) disable iff (rst)
		brownout_evt |=> cause[`RCS_BIT_BROWNOUT])
		else $error("brownout flag not set");
	a_write_no_reset: assert property (@(posedge clk_sys) disable iff (rst)
		cause_wr && !soft_evt && !brownout_evt && !system_reset_signal
		|=> !system_reset_signal)
		else $error("flag write caused reset");
	a_wdog_forced: assert property (@(posedge clk_sys) disable iff (rst)
		watchdog_fuse_enable |=> watchdog_enable)
		else $error("watchdog not forced on");
	a_illegal_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		cause[`RCS_BIT_ILLEGAL] && !cause_wr |=> cause[`RCS_BIT_ILLEGAL])
		else $error("illegal flag lost");
	a_src_brownout: assert property (@(posedge clk_sys) disable iff (rst)
		brownout_evt && !fallback |=> clock_source == $past(
			oscillator_select_fuse))
		else $error("brownout source not fuse");
	a_reset_len: assert property (@(posedge clk_sys) disable iff (rst)
		released |-> $past(rst_len) >= INTERNAL_CYC)
		else $error("system reset too short");
	a_run_clock: assert property (@(posedge clk_sys) disable iff (rst)
		cpu_run |-> $past(clock_ready))
		else $error("run without clock");
	a_monitor_start: assert property (@(posedge clk_sys) disable iff (rst)
		s_fast_release |-> s_monitor_up)
		else $error("monitor late");
	a_fail_fallback: assert property (@(posedge clk_sys) disable iff (rst)
		fallback |=> clock_source == `RCS_SRC_FRC && osc_fail_trap)
		else $error("no fallback on clock fail");

endmodule : rcs_sequencer

/* File: hw/rcs_defs.svh */
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// clock and timing, times in ns
`define RCS_CLK_NS        20
`define RCS_CYC(ns)       ((((ns)) + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_T_POWERON_NS  10000
`define RCS_T_STARTUP_NS  20000
`define RCS_T_POWER_UP_TIMER_NS     64000000
`define RCS_T_INTERNAL_NS 20000
`define RCS_T_LOCK_NS     20000
`define RCS_T_MONITOR_NS  100000
`define RCS_TMR_W         22
`define RCS_OST_LAST      10'h3ff

// register byte addresses
`define RCS_ADDR_CAUSE    4'h0
`define RCS_ADDR_OSC      4'h4
`define RCS_ADDR_STATUS   4'h8

// reset cause register
`define RCS_CAUSE_RESET   16'h0001
`define RCS_CAUSE_WMASK   16'hc1ff
`define RCS_BIT_POWERON   0
`define RCS_BIT_BROWNOUT  1
`define RCS_BIT_IDLE      2
`define RCS_BIT_SLEEP     3
`define RCS_BIT_WDOG      4
`define RCS_BIT_SWDOG_EN  5
`define RCS_BIT_SOFT      6
`define RCS_BIT_PIN       7
`define RCS_BIT_REG_STBY  8
`define RCS_BIT_ILLEGAL   14
`define RCS_BIT_TRAP      15

// oscillator control register
`define RCS_CURRENT_OSCILLATOR_FIELD_LSB      12
`define RCS_CURRENT_OSCILLATOR_FIELD_MSB      14

// clock source codes
`define RCS_SRC_FRC       3'h0
`define RCS_SRC_FRCPLL    3'h1
`define RCS_SRC_PRI       3'h2
`define RCS_SRC_PRIPLL    3'h3
`define RCS_SRC_SEC       3'h4
`define RCS_SRC_LOW_POWER_RC_OSCILLATOR      3'h5
`define RCS_SRC_EXT       3'h6
`define RCS_SRC_EXTPLL    3'h7

// status register bits
`define RCS_ST_WDOG_EN    0
`define RCS_ST_SYS_RST    1
`define RCS_ST_CLK_RDY    2
`define RCS_ST_RUN        3
`define RCS_ST_MON_ACT    4
`define RCS_ST_OSC_FAIL   5

`endif

/* File: hw/rcs_pkg.sv */
package rcs_pkg;

	typedef enum logic [2:0] {
		RCS_ST_POWERON  = 3'h0,
		RCS_ST_STARTUP  = 3'h1,
		RCS_ST_INTERNAL = 3'h2,
		RCS_ST_RUN      = 3'h3,
		RCS_ST_WAKE     = 3'h4
	} rcs_state_t;

endpackage : rcs_pkg

/* File: hw/rcs_sync.sv */
`timescale 1ns/1ps

module rcs_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end
		else
		begin
			meta <= d_async;
			q    <= meta;
		end
	end

endmodule : rcs_sync

/* File: hw/rcs_delay.sv */
`timescale 1ns/1ps

module rcs_delay #(
	parameter int W = 22
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// load a count, busy for that many cycles
	input  wire logic         start,
	input  wire logic [W-1:0] count,
	output logic              busy
);

	logic [W-1:0] cnt;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cnt <= '0;
		else if (start)
			cnt <= count;
		else if (cnt != '0)
			cnt <= cnt - W'(1);
	end

	assign busy = (cnt != '0);

endmodule : rcs_delay

/* File: tb/rcs_sequencer_test.sv */
`timescale 1ns/1ps

module rcs_sequencer_test;
	logic        clk_sys, rst, avs_read, avs_write, osc_clk_in, osc_on;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic        avs_waitrequest, system_reset_signal, cpu_run, clock_ready;
	logic        watchdog_enable, osc_fail_trap, clock_monitor_active;
	logic [2:0]  clock_source, osc_fuse;
	logic [8:0]  ev;
	logic        wd_fuse, sw_en, reg_en, mon_en;
	int          err_total = 0;
	int          compares = 0;
	int          evk[6] = '{0, 1, 2, 3, 7, 8};
	int          evb[6] = '{6, 4, 15, 14, 7, 1};
	int          i;

	// event vector: 0 soft,1 wdog,2 trap,3 illegal,4 sleep,5 idle,6 wake,
	// 7 pin held low, 8 brownout
	rcs_sequencer #(.POWER_UP_TIMER_CYCLES(22'd50), .MONITOR_CYCLES(22'd20)) DUT (
		.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h3), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.master_clear_pin_n(!ev[7]), .brownout_detect(ev[8]),
		.osc_clk_in(osc_clk_in), .software_reset_req(ev[0]),
		.watchdog_timeout(ev[1]), .trap_conflict(ev[2]),
		.illegal_access(ev[3]), .power_save_sleep(ev[4]),
		.power_save_idle(ev[5]), .wake_event(ev[6]),
		.watchdog_fuse_enable(wd_fuse), .clock_switch_enable(sw_en),
		.oscillator_select_fuse(osc_fuse), .regulator_enable(reg_en),
		.clock_monitor_enable(mon_en),
		.system_reset_signal(system_reset_signal), .cpu_run(cpu_run),
		.clock_ready(clock_ready), .watchdog_enable(watchdog_enable),
		.clock_source(clock_source), .osc_fail_trap(osc_fail_trap),
		.clock_monitor_active(clock_monitor_active)
	);

	initial
	begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end

	// oscillator stands still while off, unrelated 46 ns period
	initial
	begin
		osc_clk_in = 0;
		forever #23 osc_clk_in = osc_on ? ~osc_clk_in : 1'b0;
	end

	task end_sim;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask : chk_val

	task chk_rng(input int n, input int lo, input int hi);
		compares++;
		if (n < lo || n > hi)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, n, lo);
			err_total++;
		end
	endtask : chk_rng

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (n > 20)
			begin
				err_total++;
				end_sim();
			end
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask : bus

	task pulse(input int k, input int w);
		@(posedge clk_sys);
		ev[k] <= 1'b1;
		repeat (w) @(posedge clk_sys);
		ev[k] <= 1'b0;
	endtask : pulse

	// measures how long system reset stands once it has risen
	task rst_len(input int lo, input int hi);
		int n;
		for (n = 0; n < 10 && system_reset_signal !== 1'b1; n++)
			@(negedge clk_sys);
		for (n = 0; n < hi + 5 && system_reset_signal === 1'b1; n++)
			@(negedge clk_sys);
		chk_rng(n, lo, hi);
		if (n >= hi + 5)
		begin
			err_total++;
			end_sim();
		end
	endtask : rst_len

	task t_power_on;
		rst_len(2490, 2515);
		bus(0, 4'h0, 0);
		chk_val(rd, 32'h0001);
		chk_val(clock_source, 3'h0);
		chk_val(cpu_run, 1'b1);
		bus(0, 4'hc, 0);
		chk_val(rd, 0);
	endtask : t_power_on

	task t_soft_flags;
		bus(1, 4'h0, 32'hffdf);
		bus(0, 4'h0, 0);
		chk_val(rd, 32'hc1df);
		chk_val(system_reset_signal, 1'b0);
		bus(1, 4'h0, 0);
		bus(0, 4'h0, 0);
		chk_val(rd, 0);
	endtask : t_soft_flags

	task t_watchdog;
		bus(1, 4'h0, 32'h0020);
		repeat (2) @(negedge clk_sys);
		chk_val(watchdog_enable, 1'b1);
		bus(1, 4'h0, 0);
		repeat (2) @(negedge clk_sys);
		chk_val(watchdog_enable, 1'b0);
		@(posedge clk_sys);
		wd_fuse <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk_val(watchdog_enable, 1'b1);
		wd_fuse <= 1'b0;
	endtask : t_watchdog

	// each source sets only its own flag; brownout holds reset twice as long as the others
	task t_sources;
		for (i = 0; i < 6; i++)
		begin
			bus(1, 4'h0, 0);
			pulse(evk[i], 3);
			if (evk[i] == 8)
				rst_len(1995, 2012);
			else
				rst_len(995, 1010);
			bus(0, 4'h0, 0);
			chk_val(rd, 32'h1 << evb[i]);
		end
		pulse(3, 1);
		rst_len(995, 1010);
		pulse(7, 3);
		rst_len(995, 1010);
		bus(0, 4'h0, 0);
		chk_val(rd, 32'h4082);
	endtask : t_sources

	task t_power_save;
		int n;
		bus(1, 4'h0, 0);
		pulse(1, 1);
		rst_len(995, 1010);
		pulse(5, 1);
		bus(0, 4'h0, 0);
		chk_val(rd, 32'h0004);
		pulse(4, 1);
		repeat (10) @(posedge clk_sys);
		pulse(6, 1);
		for (n = 0; n < 5 && cpu_run !== 1'b0; n++)
			@(negedge clk_sys);
		for (n = 0; n < 1100 && cpu_run !== 1'b1; n++)
			@(negedge clk_sys);
		chk_rng(n, 990, 1010);
		chk_val(system_reset_signal, 1'b0);
		bus(0, 4'h0, 0);
		chk_val(rd, 32'h000c);
	endtask : t_power_save

	task t_clock_switch;
		int n;
		bus(1, 4'h4, 32'h2000);
		bus(0, 4'h4, 0);
		chk_val(rd[14:12], 3'h2);
		chk_val(clock_source, 3'h2);
		for (n = 0; n < 3000 && clock_ready !== 1'b1; n++)
			@(negedge clk_sys);
		chk_rng(n, 2340, 2385);
		pulse(7, 3);
		rst_len(995, 1010);
		chk_val(clock_source, 3'h2);
		pulse(8, 3);
		rst_len(1995, 2012);
		chk_val(clock_source, 3'h0);
	endtask : t_clock_switch

	// fuse picks a crystal that never starts
	task t_monitor;
		@(posedge clk_sys);
		osc_fuse <= 3'h2;
		osc_on <= 1'b0;
		pulse(8, 3);
		rst_len(1995, 2012);
		repeat (10) @(negedge clk_sys);
		chk_val(osc_fail_trap, 1'b0);
		chk_val(cpu_run, 1'b0);
		repeat (20) @(negedge clk_sys);
		chk_val(osc_fail_trap, 1'b1);
		chk_val(clock_source, 3'h0);
	endtask : t_monitor

	task t_no_switch;
		@(posedge clk_sys);
		mon_en <= 1'b0;
		osc_on <= 1'b1;
		sw_en <= 1'b0;
		bus(1, 4'h4, 32'h5000);
		chk_val(clock_source, 3'h0);
		pulse(7, 3);
		rst_len(995, 1010);
		chk_val(clock_source, 3'h2);
		@(posedge clk_sys);
		reg_en <= 1'b0;
		pulse(8, 3);
		rst_len(1045, 1062);
	endtask : t_no_switch

	task t_second_por;
		bus(1, 4'h0, 32'hc0de);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(0, 4'h0, 0);
		chk_val(rd, 32'h0001);
		chk_val(system_reset_signal, 1'b1);
	endtask : t_second_por

	initial
	begin
		rst = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		ev = 0;
		osc_on = 1;
		wd_fuse = 0;
		sw_en = 1;
		reg_en = 1;
		mon_en = 1;
		osc_fuse = 3'h0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		t_power_on();
		t_soft_flags();
		t_watchdog();
		t_sources();
		t_power_save();
		t_clock_switch();
		t_monitor();
		t_no_switch();
		t_second_por();
		end_sim();
	end
endmodule : rcs_sequencer_test
